// File: hdl/pcc_pkg.sv
// package: register map, field positions and sizes for the pwm cycle / comparator clear block
package pcc_pkg;
    localparam int unsigned ADDR_W        = 12;
    // printed offsets are not multiples of four: they are indices, byte address = 4 * index
    localparam logic [11:0] IDX_CLR_CTRL  = 12'h00CE;
    localparam logic [11:0] IDX_PWM_CFG   = 12'h00F7;
    localparam logic [11:0] IDX_VALUE0    = 12'h0100;
    localparam logic [11:0] IDX_IRQ_STAT  = 12'h0110;
    localparam logic [11:0] IDX_IRQ_MASK  = 12'h0111;
    localparam logic [11:0] IDX_MODE      = 12'h0112;
    localparam logic [11:0] IDX_STATUS    = 12'h0113;
    localparam int unsigned NUM_CH        = 3;
    // pwm_cycle_config fields
    localparam int unsigned CFG_BANK_BIT  = 7;
    localparam int unsigned CFG_IEN_BIT   = 6;
    localparam int unsigned CFG_FLAG_BIT  = 5;
    localparam logic [7:0]  CFG_WR_MASK   = 8'h00E3;
    // comparator_clear_control fields
    localparam int unsigned CLR_POL_BIT   = 7;
    localparam logic [7:0]  CLR_RESET     = 8'h0000;
    localparam logic [7:0]  CFG_RESET     = 8'h0000;
    // mode register fields: per channel g, [g]=pwm enable, [4+g]=wide pwm enable
    localparam int unsigned MODE_PWM_OFS  = 0;
    localparam int unsigned MODE_WIDE_OFS = 4;
    localparam int unsigned BASE_BITS     = 8;
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;
    // interrupt status bits
    localparam int unsigned EV_OVF        = 0;
    localparam int unsigned EV_CLR        = 1;
    localparam int unsigned NUM_EV        = 2;
    typedef enum logic [0:0] {PCC_BANK_CAPCMP, PCC_BANK_RELOAD} pcc_bank_t;
endpackage : pcc_pkg

// File: hdl/pcc_clear_unit.sv
// comparator-driven clear of channel outputs
`timescale 1ns/10ps
module pcc_clear_unit #(
    parameter int unsigned NUM_CH = 3
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              cmp_result,
    input  wire logic              polarity,
    input  wire logic [NUM_CH-1:0] enable,
    output logic      [NUM_CH-1:0] clear_pulse,
    output logic                   edge_seen
);
    logic cmp_q;
    logic rise;
    logic fall;

    always_ff @(posedge clk) begin
        if (srst) begin
            cmp_q <= 1'b0;
        end else begin
            cmp_q <= cmp_result;
        end
    end

    assign rise = cmp_result & ~cmp_q;
    assign fall = ~cmp_result & cmp_q;
    // polarity 0 clears on going low, 1 on going high
    assign edge_seen = polarity ? rise : fall;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            assign clear_pulse[g] = edge_seen & enable[g];
        end
    endgenerate
endmodule : pcc_clear_unit

// File: hdl/pcc_top.sv
// pwm cycle configuration and comparator clear with axi4-lite registers
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
// What this block does
// - bank select 0 steers value-register accesses to capture/compare, 1 to auto-reload.
// - auto-reload value used only for 9, 10 and 11-bit pwm channels.
// - overflow interrupt requested while flag set and enable is one.
// - flag sets on counter overflow out of bit chosen by cycle length.
// - software may set the flag; hardware never clears it.
// - cycle length codes 00..11 give 8..11 bit cycles for non-wide pwm.
// - wide 16-bit pwm channels ignore cycle length select.
// - clear polarity chooses falling (0) or rising (1) comparator edge.
// - enable bits 2..0 turn on comparator clearing per channel.
// - config bits 4..2 read zero and ignore writes.
// - wide mode bit selects 16-bit pwm when pwm enabled.
module pcc_top #(
    parameter int unsigned NUM_CH = pcc_pkg::NUM_CH
) (
    input  wire logic                       CLK,
    input  wire logic                       SRST,
    input  wire logic [pcc_pkg::ADDR_W+1:0] S_AXI_AWADDR,
    input  wire logic                       S_AXI_AWVALID,
    output logic                            S_AXI_AWREADY,
    input  wire logic [31:0]                S_AXI_WDATA,
    input  wire logic [3:0]                 S_AXI_WSTRB,
    input  wire logic                       S_AXI_WVALID,
    output logic                            S_AXI_WREADY,
    output logic [1:0]                      S_AXI_BRESP,
    output logic                            S_AXI_BVALID,
    input  wire logic                       S_AXI_BREADY,
    input  wire logic [pcc_pkg::ADDR_W+1:0] S_AXI_ARADDR,
    input  wire logic                       S_AXI_ARVALID,
    output logic                            S_AXI_ARREADY,
    output logic [31:0]                     S_AXI_RDATA,
    output logic [1:0]                      S_AXI_RRESP,
    output logic                            S_AXI_RVALID,
    input  wire logic                       S_AXI_RREADY,
    input  wire logic [15:0]                COUNTER_VALUE,
    input  wire logic                       COUNTER_TICK,
    input  wire logic                       CMP_RESULT,
    output logic [NUM_CH-1:0]               CHANNEL_CLEAR,
    output logic [NUM_CH-1:0]               CHANNEL_RELOAD_USE,
    output logic [NUM_CH*16-1:0]            CAPCMP_VALUE,
    output logic [NUM_CH*16-1:0]            RELOAD_VALUE,
    output logic [1:0]                      CYCLE_BITS_SEL,
    output logic                            IRQ
);
    localparam int unsigned AW = pcc_pkg::ADDR_W;

    logic [7:0]               clr_q;
    logic [7:0]               cfg_q;
    logic [7:0]               mode_q;
    logic [15:0]              capcmp_q [NUM_CH];
    logic [15:0]              reload_q [NUM_CH];
    logic [pcc_pkg::NUM_EV-1:0] stat_q;
    logic [pcc_pkg::NUM_EV-1:0] mask_q;
    logic [AW-1:0]            aw_idx_q;
    logic                     aw_have_q;
    logic [31:0]              wd_q;
    logic [3:0]               ws_q;
    logic                     w_have_q;
    logic                     bvalid_q;
    logic [1:0]               bresp_q;
    logic                     rvalid_q;
    logic [31:0]              rdata_q;
    logic [1:0]               rresp_q;
    logic                     wr_go;
    logic                     ovf_ev;
    logic                     clr_edge;
    logic [NUM_CH-1:0]        clr_pulse;
    logic [15:0]              cnt_prev_q;
    logic [3:0]               watch_bit;
    pcc_pkg::pcc_bank_t       bank;

    // index of a byte address; the two low address bits are ignored
    function automatic logic [AW-1:0] to_idx(input logic [AW+1:0] a);
        to_idx = a[AW+1:2];
    endfunction : to_idx

    // decode: channel number if the index hits a value register, else NUM_CH
    function automatic int unsigned value_ch(input logic [AW-1:0] idx);
        value_ch = NUM_CH;
        for (int unsigned i = 0; i < NUM_CH; i++) begin
            if (idx == pcc_pkg::IDX_VALUE0 + AW'(i)) begin
                value_ch = i;
            end
        end
    endfunction : value_ch

    function automatic logic is_mapped(input logic [AW-1:0] idx);
        is_mapped = (idx == pcc_pkg::IDX_CLR_CTRL) || (idx == pcc_pkg::IDX_PWM_CFG)
                 || (idx == pcc_pkg::IDX_IRQ_STAT) || (idx == pcc_pkg::IDX_IRQ_MASK)
                 || (idx == pcc_pkg::IDX_MODE) || (idx == pcc_pkg::IDX_STATUS)
                 || (value_ch(idx) < NUM_CH);
    endfunction : is_mapped

    assign bank = pcc_pkg::pcc_bank_t'(cfg_q[pcc_pkg::CFG_BANK_BIT]);

    // ---------------- write path: address and data taken in either order
    assign S_AXI_AWREADY = ~aw_have_q & ~bvalid_q;
    assign S_AXI_WREADY  = ~w_have_q & ~bvalid_q;
    assign wr_go         = aw_have_q & w_have_q & ~bvalid_q;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            aw_have_q <= 1'b0;
            aw_idx_q  <= '0;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_have_q <= 1'b1;
            aw_idx_q  <= to_idx(S_AXI_AWADDR);
        end else if (wr_go) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            w_have_q <= 1'b0;
            wd_q     <= '0;
            ws_q     <= '0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_have_q <= 1'b1;
            wd_q     <= S_AXI_WDATA;
            ws_q     <= S_AXI_WSTRB;
        end else if (wr_go) begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            bvalid_q <= 1'b0;
            bresp_q  <= pcc_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= is_mapped(aw_idx_q) ? pcc_pkg::RESP_OKAY : pcc_pkg::RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP  = bresp_q;

    // ---------------- configuration registers
    always_ff @(posedge CLK) begin
        if (SRST) begin
            clr_q <= pcc_pkg::CLR_RESET;
        end else if (wr_go && ws_q[0] && aw_idx_q == pcc_pkg::IDX_CLR_CTRL) begin
            clr_q <= wd_q[7:0];
        end
    end

    // cycle overflow flag: hardware only sets, software writes set or clear; set wins
    always_ff @(posedge CLK) begin
        if (SRST) begin
            cfg_q <= pcc_pkg::CFG_RESET;
        end else begin
            if (wr_go && ws_q[0] && aw_idx_q == pcc_pkg::IDX_PWM_CFG) begin
                cfg_q <= wd_q[7:0] & pcc_pkg::CFG_WR_MASK;
            end
            if (ovf_ev) begin
                cfg_q[pcc_pkg::CFG_FLAG_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            mode_q <= '0;
        end else if (wr_go && ws_q[0] && aw_idx_q == pcc_pkg::IDX_MODE) begin
            mode_q <= wd_q[7:0];
        end
    end

    // value registers: same address, bank chosen by the select bit
    always_ff @(posedge CLK) begin
        if (SRST) begin
            for (int unsigned i = 0; i < NUM_CH; i++) begin
                capcmp_q[i] <= '0;
                reload_q[i] <= '0;
            end
        end else if (wr_go && value_ch(aw_idx_q) < NUM_CH) begin
            for (int unsigned i = 0; i < NUM_CH; i++) begin
                if (value_ch(aw_idx_q) == i) begin
                    for (int unsigned b = 0; b < 2; b++) begin
                        if (ws_q[b]) begin
                            if (bank == pcc_pkg::PCC_BANK_RELOAD) begin
                                reload_q[i][b*8 +: 8] <= wd_q[b*8 +: 8];
                            end else begin
                                capcmp_q[i][b*8 +: 8] <= wd_q[b*8 +: 8];
                            end
                        end
                    end
                end
            end
        end
    end

    // ---------------- cycle overflow detection
    // overflow out of bit n shows as that counter bit falling on a counter step
    assign watch_bit = 4'(pcc_pkg::BASE_BITS - 1) + {2'b00, cfg_q[1:0]};

    always_ff @(posedge CLK) begin
        if (SRST) begin
            cnt_prev_q <= '0;
        end else if (COUNTER_TICK) begin
            cnt_prev_q <= COUNTER_VALUE;
        end
    end
    // sampling only on ticks keeps a stalled counter from faking an edge
    assign ovf_ev = COUNTER_TICK & cnt_prev_q[watch_bit] & ~COUNTER_VALUE[watch_bit];

    // ---------------- comparator clear
    pcc_clear_unit #(
        .NUM_CH(NUM_CH)
    ) u_clear (
        .clk        (CLK),
        .srst       (SRST),
        .cmp_result (CMP_RESULT),
        .polarity   (clr_q[pcc_pkg::CLR_POL_BIT]),
        .enable     (clr_q[NUM_CH-1:0]),
        .clear_pulse(clr_pulse),
        .edge_seen  (clr_edge)
    );

    always_ff @(posedge CLK) begin
        if (SRST) begin
            CHANNEL_CLEAR <= '0;
        end else begin
            CHANNEL_CLEAR <= clr_pulse;
        end
    end

    // ---------------- per-channel mode outputs
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_out
            logic pwm_on;
            logic wide;
            assign pwm_on = mode_q[pcc_pkg::MODE_PWM_OFS + g];
            assign wide   = pwm_on & mode_q[pcc_pkg::MODE_WIDE_OFS + g];
            // reload only for 9..11 bit pwm; wide channels ignore cycle length
            always_ff @(posedge CLK) begin
                if (SRST) begin
                    CHANNEL_RELOAD_USE[g] <= 1'b0;
                end else begin
                    CHANNEL_RELOAD_USE[g] <= pwm_on & ~wide & (cfg_q[1:0] != 2'b00);
                end
            end
            always_ff @(posedge CLK) begin
                if (SRST) begin
                    CAPCMP_VALUE[g*16 +: 16] <= '0;
                    RELOAD_VALUE[g*16 +: 16] <= '0;
                end else begin
                    CAPCMP_VALUE[g*16 +: 16] <= capcmp_q[g];
                    RELOAD_VALUE[g*16 +: 16] <= reload_q[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (SRST) begin
            CYCLE_BITS_SEL <= '0;
        end else begin
            CYCLE_BITS_SEL <= cfg_q[1:0];
        end
    end

    // ---------------- interrupt status, write one to clear, set wins
    always_ff @(posedge CLK) begin
        if (SRST) begin
            stat_q <= '0;
        end else begin
            for (int unsigned e = 0; e < pcc_pkg::NUM_EV; e++) begin
                if (wr_go && ws_q[0] && aw_idx_q == pcc_pkg::IDX_IRQ_STAT && wd_q[e]) begin
                    stat_q[e] <= 1'b0;
                end
            end
            if (ovf_ev) begin
                stat_q[pcc_pkg::EV_OVF] <= 1'b1;
            end
            if (clr_edge && |clr_q[NUM_CH-1:0]) begin
                stat_q[pcc_pkg::EV_CLR] <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            mask_q <= '0;
        end else if (wr_go && ws_q[0] && aw_idx_q == pcc_pkg::IDX_IRQ_MASK) begin
            mask_q <= wd_q[pcc_pkg::NUM_EV-1:0];
        end
    end

    // level request while the flag stands and its enable is set
    assign IRQ = (cfg_q[pcc_pkg::CFG_FLAG_BIT] & cfg_q[pcc_pkg::CFG_IEN_BIT])
               | |(stat_q & mask_q);

    // ---------------- read path, one cycle after address
    assign S_AXI_ARREADY = ~rvalid_q;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= pcc_pkg::RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            logic [AW-1:0] idx;
            int unsigned   ch;
            idx      = to_idx(S_AXI_ARADDR);
            ch       = value_ch(idx);
            rvalid_q <= 1'b1;
            rresp_q  <= is_mapped(idx) ? pcc_pkg::RESP_OKAY : pcc_pkg::RESP_SLVERR;
            rdata_q  <= '0;
            if (idx == pcc_pkg::IDX_CLR_CTRL) begin
                rdata_q <= {24'h00_0000, clr_q};
            end else if (idx == pcc_pkg::IDX_PWM_CFG) begin
                rdata_q <= {24'h00_0000, cfg_q};
            end else if (idx == pcc_pkg::IDX_IRQ_STAT) begin
                rdata_q <= 32'(stat_q);
            end else if (idx == pcc_pkg::IDX_IRQ_MASK) begin
                rdata_q <= 32'(mask_q);
            end else if (idx == pcc_pkg::IDX_MODE) begin
                rdata_q <= {24'h00_0000, mode_q};
            end else if (idx == pcc_pkg::IDX_STATUS) begin
                rdata_q <= {30'h0000_0000, CMP_RESULT, IRQ};
            end else if (ch < NUM_CH) begin
                rdata_q <= (bank == pcc_pkg::PCC_BANK_RELOAD) ? 32'(reload_q[ch])
                                                              : 32'(capcmp_q[ch]);
            end
        end else if (S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA  = rdata_q;
    assign S_AXI_RRESP  = rresp_q;
endmodule : pcc_top

// File: testbench/pcc_top_assertions.sv
// checker: port-level assertions for the pwm cycle / comparator clear block
`timescale 1ns/10ps
module pcc_top_checker #(
    parameter int unsigned NUM_CH = 3
) (
    input wire logic                 CLK,
    input wire logic                 SRST,
    input wire logic                 S_AXI_AWVALID,
    input wire logic                 S_AXI_AWREADY,
    input wire logic                 S_AXI_WVALID,
    input wire logic                 S_AXI_WREADY,
    input wire logic                 S_AXI_BVALID,
    input wire logic                 S_AXI_ARVALID,
    input wire logic                 S_AXI_ARREADY,
    input wire logic                 S_AXI_RVALID,
    input wire logic                 CMP_RESULT,
    input wire logic [NUM_CH-1:0]    CHANNEL_CLEAR,
    input wire logic [NUM_CH-1:0]    CHANNEL_RELOAD_USE,
    input wire logic [NUM_CH*16-1:0] CAPCMP_VALUE,
    input wire logic [NUM_CH*16-1:0] RELOAD_VALUE,
    input wire logic [1:0]           CYCLE_BITS_SEL,
    input wire logic                 IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    a_reset_clears_all: assert property ($fell(SRST) |-> !IRQ && CYCLE_BITS_SEL == 2'b00
        && CHANNEL_RELOAD_USE == '0 && CHANNEL_CLEAR == '0) else $error("outputs not zero");
    a_clear_needs_edge: assert property (CHANNEL_CLEAR != '0 |->
        $past(CMP_RESULT) != $past(CMP_RESULT, 2)) else $error("clear without edge");
    a_clear_one_cycle: assert property (CHANNEL_CLEAR != '0 && $stable(CMP_RESULT)
        |=> CHANNEL_CLEAR == '0) else $error("clear pulse too long");
    a_reload_not_eight: assert property (CHANNEL_RELOAD_USE != '0 |->
        CYCLE_BITS_SEL != 2'b00 || $past(CYCLE_BITS_SEL) != 2'b00) else $error("reload in 8 bit");
    a_value_on_write: assert property ($changed(CAPCMP_VALUE) || $changed(RELOAD_VALUE)
        |-> S_AXI_BVALID || $past(S_AXI_BVALID)) else $error("value changed without write");
    a_read_answers: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read not answered");
    a_write_answers: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
        && S_AXI_WREADY |-> ##2 S_AXI_BVALID) else $error("write not answered");
    a_read_refused: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read taken while answering");
    c_clear: cover property (CHANNEL_CLEAR != '0);
    c_irq: cover property ($rose(IRQ));
    c_reload: cover property (CHANNEL_RELOAD_USE != '0);
endmodule : pcc_top_checker

bind pcc_top pcc_top_checker #(.NUM_CH(NUM_CH)) u_chk (.CLK(CLK), .SRST(SRST),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID), .CMP_RESULT(CMP_RESULT), .CHANNEL_CLEAR(CHANNEL_CLEAR),
    .CHANNEL_RELOAD_USE(CHANNEL_RELOAD_USE), .CAPCMP_VALUE(CAPCMP_VALUE),
    .RELOAD_VALUE(RELOAD_VALUE), .CYCLE_BITS_SEL(CYCLE_BITS_SEL), .IRQ(IRQ));

// File: testbench/pcc_top_bench.sv
// testbench: register-level tests of the pwm cycle / comparator clear block
`timescale 1ns/10ps
module pcc_top_bench;
    logic        clk, srst, awvalid, wvalid, bready, arvalid, rready, cnt_tick, cmp;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [13:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rdat;
    logic [15:0] cnt_val;
    logic [1:0]  bresp, rresp, sel_o, resp;
    logic [2:0]  clr, rl_use, clr_last, en;
    logic [47:0] capv, relv;
    int          err_count, cmp_count, clr_n, n0;
    // cfg sel, mode byte, expected reload use
    logic [15:0] t5 [5] = '{16'h0070, 16'h2077, 16'h2176, 16'h3700, 16'h1066};
    pcc_top dut (.CLK(clk), .SRST(srst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .COUNTER_VALUE(cnt_val), .COUNTER_TICK(cnt_tick), .CMP_RESULT(cmp),
        .CHANNEL_CLEAR(clr), .CHANNEL_RELOAD_USE(rl_use), .CAPCMP_VALUE(capv),
        .RELOAD_VALUE(relv), .CYCLE_BITS_SEL(sel_o), .IRQ(irq));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // sole writer of the pulse record; tests snapshot the count instead of clearing it
    always @(posedge clk) begin
        if (clr != 3'b000) begin
            clr_last <= clr;
            clr_n    <= clr_n + 1;
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    // ready is sampled at the falling edge: inputs only move at rising edges, so no race
    task automatic wr(input logic [11:0] i, input logic [31:0] d);
        logic sa, sw, sb;
        sb = 1'b0;
        @(posedge clk);
        awaddr  <= {i, 2'b00};
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!sb) begin
            @(negedge clk);
            sa = awready;
            sw = wready;
            sb = bvalid;
            resp = bresp;
            @(posedge clk);
            if (sa) awvalid <= 1'b0;
            if (sw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [11:0] i);
        logic sa, sr;
        sr = 1'b0;
        @(posedge clk);
        araddr  <= {i, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!sr) begin
            @(negedge clk);
            sa = arready;
            sr = rvalid;
            rdat = rdata;
            resp = rresp;
            @(posedge clk);
            if (sa) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        #1;
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt
    task automatic tick(input logic [15:0] v);
        @(posedge clk);
        cnt_val  <= v;
        cnt_tick <= 1'b1;
        @(posedge clk);
        cnt_tick <= 1'b0;
    endtask : tick
    task automatic setcmp(input logic v);
        @(posedge clk);
        cmp <= v;
        wt(3);
    endtask : setcmp
    task automatic chk_reset();
        rd(pcc_pkg::IDX_CLR_CTRL);
        chk(rdat, 32'h0000_0000);
        rd(pcc_pkg::IDX_PWM_CFG);
        chk(rdat, 32'h0000_0000);
        chk(32'(sel_o), 32'h0000_0000);
        $display("test reset values done");
    endtask : chk_reset
    initial begin
        repeat (10000) @(posedge clk);
        err_count++;
        stop_test();
    end
    initial begin
        {srst, awvalid, wvalid, bready, arvalid, rready, cnt_tick, cmp} = 8'h80;
        {awaddr, araddr, wdata, cnt_val} = '0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        chk_reset();
        wr(pcc_pkg::IDX_PWM_CFG, 32'h0000_00FF);
        rd(pcc_pkg::IDX_PWM_CFG);
        chk(rdat, 32'h0000_00E3);
        chk(32'(irq), 32'h0000_0001);
        chk(32'(sel_o), 32'h0000_0003);
        wr(pcc_pkg::IDX_PWM_CFG, 32'h0000_0023);
        chk(32'(irq), 32'h0000_0000);
        wr(pcc_pkg::IDX_PWM_CFG, 32'h0000_0003);
        rd(pcc_pkg::IDX_PWM_CFG);
        chk(rdat, 32'h0000_0003);
        $display("test config fields done");
        for (int c = 0; c < 3; c++) begin
            wr(pcc_pkg::IDX_PWM_CFG, 32'h0000_0000);
            wr(pcc_pkg::IDX_VALUE0 + 12'(c), 32'h0000_1230 + 32'(c));
            wr(pcc_pkg::IDX_PWM_CFG, 32'h0000_0080);
            wr(pcc_pkg::IDX_VALUE0 + 12'(c), 32'h0000_ABC0 + 32'(c));
            rd(pcc_pkg::IDX_VALUE0 + 12'(c));
            chk(rdat, 32'h0000_ABC0 + 32'(c));
            chk(32'(relv[16*c +: 16]), 32'h0000_ABC0 + 32'(c));
            chk(32'(capv[16*c +: 16]), 32'h0000_1230 + 32'(c));
        end
        wr(pcc_pkg::IDX_PWM_CFG, 32'h0000_0000);
        rd(pcc_pkg::IDX_VALUE0 + 12'h002);
        chk(rdat, 32'h0000_1232);
        $display("test bank select done");
        for (int s = 0; s < 4; s++) begin
            wr(pcc_pkg::IDX_PWM_CFG, 32'h0000_0040 + 32'(s));
            tick(16'(1) << (6 + s));
            tick(16'h0000);
            wt(2);
            chk(32'(irq), 32'h0000_0000);
            tick(16'(1) << (7 + s));
            tick(16'h0000);
            wt(2);
            chk(32'(irq), 32'h0000_0001);
            tick(16'(1) << (8 + s));
            tick(16'h0000);
            rd(pcc_pkg::IDX_PWM_CFG);
            chk(rdat, 32'h0000_0060 + 32'(s));
            wr(pcc_pkg::IDX_PWM_CFG, 32'h0000_0040 + 32'(s));
        end
        $display("test cycle overflow done");
        for (int k = 0; k < 5; k++) begin
            wr(pcc_pkg::IDX_PWM_CFG, 32'(t5[k][15:12]));
            wr(pcc_pkg::IDX_MODE, 32'(t5[k][11:4]));
            wt(2);
            chk(32'(rl_use), 32'(t5[k][3:0]));
            chk(32'(sel_o), 32'(t5[k][15:12]));
        end
        $display("test reload use done");
        wr(pcc_pkg::IDX_MODE, 32'h0000_0000);
        wr(pcc_pkg::IDX_IRQ_STAT, 32'h0000_0003);
        for (int p = 0; p < 2; p++) begin
            en = (p == 0) ? 3'b101 : 3'b010;
            wr(pcc_pkg::IDX_CLR_CTRL, {24'h00_0000, p[0], 4'h0, en});
            setcmp(p[0]);
            n0 = clr_n;
            setcmp(!p[0]);
            chk(32'(clr_n - n0), 32'h0000_0000);
            setcmp(p[0]);
            chk(32'(clr_last), 32'(en));
            chk(32'(clr_n - n0), 32'h0000_0001);
        end
        rd(pcc_pkg::IDX_IRQ_STAT);
        chk(rdat, 32'h0000_0002);
        chk(32'(irq), 32'h0000_0000);
        wr(pcc_pkg::IDX_IRQ_MASK, 32'h0000_0002);
        chk(32'(irq), 32'h0000_0001);
        // status word: bit 1 comparator level, bit 0 interrupt line
        rd(pcc_pkg::IDX_STATUS);
        chk(rdat, 32'h0000_0003);
        wr(pcc_pkg::IDX_IRQ_STAT, 32'h0000_0002);
        chk(32'(irq), 32'h0000_0000);
        $display("test comparator clear done");
        wr(12'h0FF, 32'h0000_00FF);
        chk(32'(resp), 32'(pcc_pkg::RESP_SLVERR));
        rd(12'h0FF);
        chk(rdat, 32'h0000_0000);
        chk(32'(resp), 32'(pcc_pkg::RESP_SLVERR));
        rd(pcc_pkg::IDX_CLR_CTRL);
        chk(rdat, 32'h0000_0082);
        chk(32'(resp), 32'(pcc_pkg::RESP_OKAY));
        $display("test unmapped access done");
        setcmp(1'b0);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        chk_reset();
        stop_test();
    end
endmodule : pcc_top_bench
